// file: shared/cis_consts.vh
// constants for the core interrupt sequencer
`ifndef CIS_CONSTS_VH
`define CIS_CONSTS_VH
`define CIS_GIE_BIT 7
`define CIS_RESET_VEC 12'h000
`define CIS_ENTRY_CYC 3'h4
`define CIS_WAKE_CYC 3'h4
`define CIS_VJMP_CYC 3'h3
`define CIS_RET_CYC 3'h4
`define CIS_SP_STEP 16'h0002
`define CIS_SP_RESET 16'h025f
`endif

// file: verilog/cis_flag_bank.v
// per-source pending flags and request gating
`timescale 1ns/1ps
module cis_flag_bank #(
  parameter NSRC = 8
) (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // sources
  input wire [NSRC-1:0] evt_i,
  input wire [NSRC-1:0] level_type_i,
  input wire [NSRC-1:0] src_en_i,
  // software write-one-to-clear
  input wire flag_wr_i,
  input wire [NSRC-1:0] flag_wdata_i,
  // hardware clear on service
  input wire [NSRC-1:0] svc_clr_i,
  // state
  output wire [NSRC-1:0] flags_o,
  output wire [NSRC-1:0] req_o
);
  reg [NSRC-1:0] flag_q;
  reg [NSRC-1:0] flag_d;
  reg [NSRC-1:0] sw_clr;

  ////////////////////////////////////////////////////////////////////////
  // flags set regardless of enable; set beats any clear in the same cycle
  always @*
  begin
    sw_clr = flag_wr_i ? flag_wdata_i : {NSRC{1'b0}};
    flag_d = (flag_q & ~sw_clr & ~svc_clr_i) | (evt_i & ~level_type_i);
  end

  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      flag_q <= {NSRC{1'b0}};
    else
      flag_q <= flag_d;
  end

  // level sources request only while the condition stands
  assign req_o = src_en_i & ((flag_q & ~level_type_i) | (evt_i & level_type_i));
  assign flags_o = flag_q;
endmodule

// file: verilog/cis_sequencer.v
// interrupt acceptance, priority and entry/return sequencing
`timescale 1ns/1ps
`include "cis_consts.vh"
module cis_sequencer #(
  parameter NSRC = 8,
  parameter PCW = 12,
  parameter SPW = 16
) (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // interrupt sources
  input wire [NSRC-1:0] irq_evt_i,
  input wire [NSRC-1:0] irq_level_type_i,
  input wire [NSRC-1:0] irq_src_en_i,
  // pending flag write-one-to-clear
  input wire flag_wr_i,
  input wire [NSRC-1:0] flag_wdata_i,
  // pipeline instruction boundary and instruction kinds
  input wire instr_done_i,
  input wire sleeping_i,
  input wire wake_ready_i,
  input wire set_global_enable_instr_i,
  input wire clear_global_enable_instr_i,
  input wire return_from_handler_instr_i,
  input wire [PCW-1:0] next_pc_i,
  // status register write by software
  input wire status_wr_i,
  input wire [7:0] status_wdata_i,
  // stack pointer load by software
  input wire sp_wr_i,
  input wire [SPW-1:0] sp_wdata_i,
  // stack pop data
  input wire [7:0] stack_rdata_i,
  // sequencer outputs
  output reg busy_o,
  output reg pc_load_o,
  output reg [PCW-1:0] program_counter_o,
  output reg stack_wr_o,
  output reg stack_rd_o,
  output reg [SPW-1:0] stack_addr_o,
  output reg [7:0] stack_wdata_o,
  output reg [7:0] status_flag_register_o,
  output reg [SPW-1:0] sp_o,
  output reg [NSRC-1:0] flags_o,
  output reg [NSRC-1:0] ack_o
);

  ////////////////////////////////////////////////////////////////////////
  // states
  localparam ST_RUN = 3'h0;
  localparam ST_WAKE = 3'h1;
  localparam ST_ENTRY = 3'h2;
  localparam ST_VJMP = 3'h3;
  localparam ST_RET = 3'h4;

  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg [NSRC-1:0] win_q;
  reg [PCW-1:0] ret_pc_q;
  reg hold_one_q;
  reg [NSRC-1:0] svc_clr;
  wire [NSRC-1:0] flags;
  wire [NSRC-1:0] req;
  wire gie;

  // lowest index = lowest vector = highest priority
  function [NSRC-1:0] pick_first;
    input [NSRC-1:0] v;
    integer i;
    reg found;
    begin
      pick_first = {NSRC{1'b0}};
      found = 1'b0;
      for (i = 0; i < NSRC; i = i + 1)
      begin
        if (v[i] && !found)
        begin
          pick_first[i] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  // vector word address of a one-hot source; vector 0 is reset
  function [PCW-1:0] vec_of;
    input [NSRC-1:0] oh;
    integer i;
    begin
      vec_of = `CIS_RESET_VEC;
      for (i = 0; i < NSRC; i = i + 1)
      begin
        if (oh[i])
          vec_of = i[PCW-1:0] + 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // flag bank
  cis_flag_bank #(.NSRC(NSRC)) u_flags (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .evt_i(irq_evt_i),
    .level_type_i(irq_level_type_i),
    .src_en_i(irq_src_en_i),
    .flag_wr_i(flag_wr_i),
    .flag_wdata_i(flag_wdata_i),
    .svc_clr_i(svc_clr),
    .flags_o(flags),
    .req_o(req)
  );

  assign gie = status_flag_register_o[`CIS_GIE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // acceptance: instruction boundary or sleep, enable set, no hold-off pending;
  // clear-enable in this cycle vetoes, so a racing request stays pending
  wire accept;
  wire [NSRC-1:0] winner;
  assign winner = pick_first(req);
  assign accept = (state_q == ST_RUN) && gie && (|req) && (instr_done_i || sleeping_i)
    && !hold_one_q && !clear_global_enable_instr_i;

  // hardware flag clear on service, only for flag-type sources
  always @*
  begin
    svc_clr = accept ? (winner & ~irq_level_type_i) : {NSRC{1'b0}};
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_RUN;
      cnt_q <= 3'h0;
      win_q <= {NSRC{1'b0}};
      ret_pc_q <= {PCW{1'b0}};
      hold_one_q <= 1'b0;
      busy_o <= 1'b0;
      pc_load_o <= 1'b1;
      program_counter_o <= `CIS_RESET_VEC;
      stack_wr_o <= 1'b0;
      stack_rd_o <= 1'b0;
      stack_addr_o <= {SPW{1'b0}};
      stack_wdata_o <= 8'h00;
      status_flag_register_o <= 8'h00;
      sp_o <= `CIS_SP_RESET;
      flags_o <= {NSRC{1'b0}};
      ack_o <= {NSRC{1'b0}};
    end
    else
    begin
      pc_load_o <= 1'b0;
      stack_wr_o <= 1'b0;
      stack_rd_o <= 1'b0;
      ack_o <= {NSRC{1'b0}};
      flags_o <= flags;
      // status is not stacked; only its gie bit is cleared on entry and set on return here
      if (status_wr_i)
        status_flag_register_o <= status_wdata_i;
      if (sp_wr_i)
        sp_o <= sp_wdata_i;
      // one instruction must retire after set-enable or a return
      if (instr_done_i)
        hold_one_q <= 1'b0;
      case (state_q)
        ST_RUN:
        begin
          if (clear_global_enable_instr_i)
            status_flag_register_o[`CIS_GIE_BIT] <= 1'b0;
          else if (set_global_enable_instr_i)
          begin
            status_flag_register_o[`CIS_GIE_BIT] <= 1'b1;
            hold_one_q <= 1'b1;
          end
          if (return_from_handler_instr_i && instr_done_i)
          begin
            state_q <= ST_RET;
            cnt_q <= 3'h1;
            busy_o <= 1'b1;
            stack_rd_o <= 1'b1;
            stack_addr_o <= sp_o + 1'b1;
          end
          else if (accept)
          begin
            win_q <= winner;
            ack_o <= winner;
            ret_pc_q <= next_pc_i;
            busy_o <= 1'b1;
            status_flag_register_o[`CIS_GIE_BIT] <= 1'b0;
            cnt_q <= 3'h1;
            state_q <= sleeping_i ? ST_WAKE : ST_ENTRY;
          end
        end
        ST_WAKE:
        begin
          // sleep start-up is covered by wake_ready; then four more cycles
          if (wake_ready_i)
          begin
            if (cnt_q == `CIS_WAKE_CYC)
            begin
              cnt_q <= 3'h1;
              state_q <= ST_ENTRY;
            end
            else
              cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_ENTRY:
        begin
          // low byte pushed first, sp falls by two in all
          if (cnt_q == 3'h1 || cnt_q == 3'h2)
          begin
            stack_wr_o <= 1'b1;
            stack_addr_o <= sp_o;
            stack_wdata_o <= (cnt_q == 3'h1) ? ret_pc_q[7:0]
              : {{(16-PCW){1'b0}}, ret_pc_q[PCW-1:8]};
            sp_o <= sp_o - 1'b1;
          end
          if (cnt_q == `CIS_ENTRY_CYC)
          begin
            pc_load_o <= 1'b1;
            program_counter_o <= vec_of(win_q);
            cnt_q <= 3'h1;
            state_q <= ST_VJMP;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_VJMP:
        begin
          // vector word executes its jump; pipeline loads the target
          if (cnt_q == `CIS_VJMP_CYC)
          begin
            busy_o <= 1'b0;
            state_q <= ST_RUN;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_RET:
        begin
          // pop data stands the cycle after each read strobe
          if (cnt_q == 3'h1)
          begin
            stack_rd_o <= 1'b1;
            stack_addr_o <= sp_o + `CIS_SP_STEP;
          end
          if (cnt_q == 3'h2)
            ret_pc_q[PCW-1:8] <= stack_rdata_i[PCW-9:0];
          if (cnt_q == 3'h3)
            ret_pc_q[7:0] <= stack_rdata_i;
          if (cnt_q == `CIS_RET_CYC)
          begin
            sp_o <= sp_o + `CIS_SP_STEP;
            status_flag_register_o[`CIS_GIE_BIT] <= 1'b1;
            pc_load_o <= 1'b1;
            program_counter_o <= ret_pc_q;
            hold_one_q <= 1'b1;
            busy_o <= 1'b0;
            state_q <= ST_RUN;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        default:
        begin
          state_q <= ST_RUN;
          busy_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: tb/cis_stack_model.sv
// stack memory model facing the sequencer
`timescale 1ns/1ps
module cis_stack_model (
  // clock and stack port
  input wire mclk_i,
  input wire rd_i,
  input wire wr_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  // pop data
  output reg [7:0] rdata_o
);
  reg [7:0] mem_q [0:255];
  initial rdata_o = 8'h00;
  ////////////////////////////////////////////////////////////
  // pop data valid one cycle after a read, else a changing pattern
  // so a late sample never sees stale data
  always @(posedge mclk_i)
  begin
    if (wr_i)
      mem_q[addr_i[7:0]] <= wdata_i;
    rdata_o <= rd_i ? mem_q[addr_i[7:0]] : ~rdata_o;
  end
endmodule

// file: tb/cis_sequencer_monitor.sv
// assertion checker for the interrupt sequencer
`timescale 1ns/1ps
module cis_sequencer_monitor #(
  parameter NSRC = 8,
  parameter PCW = 12
) (
  // clock, reset and inputs
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [NSRC-1:0] irq_src_en_i,
  input wire instr_done_i,
  input wire clear_global_enable_instr_i,
  input wire return_from_handler_instr_i,
  // outputs
  input wire busy_o,
  input wire pc_load_o,
  input wire [PCW-1:0] program_counter_o,
  input wire stack_wr_o,
  input wire [15:0] stack_addr_o,
  input wire [7:0] status_flag_register_o,
  input wire [NSRC-1:0] ack_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////
  // acceptance
  src_gate_a: assert property ((ack_o & ~$past(irq_src_en_i)) == 0)
    else $error("ack from disabled source");
  ack_onehot_a: assert property (|ack_o |-> $onehot(ack_o))
    else $error("ack not one-hot");
  entry_gie_a: assert property (|ack_o |-> !status_flag_register_o[7])
    else $error("gie kept on entry");
  gie_block_a: assert property (!status_flag_register_o[7] |=> ack_o == 0)
    else $error("ack while gie clear");
  cli_block_a: assert property (clear_global_enable_instr_i |=> ack_o == 0)
    else $error("ack after clear-enable");
  // entry and return sequencing
  entry_latency_a: assert property (|ack_o |-> !pc_load_o [*4] ##1 pc_load_o)
    else $error("vector load not four cycles after ack");
  vector_jump_a: assert property (|ack_o |-> busy_o [*7] ##1 !busy_o)
    else $error("busy span wrong");
  push_pair_a: assert property (|ack_o |=> stack_wr_o ##1
    (stack_wr_o && stack_addr_o == $past(stack_addr_o) - 16'h0001))
    else $error("push pair wrong");
  return_time_a: assert property (return_from_handler_instr_i && instr_done_i |->
    ##5 (pc_load_o && status_flag_register_o[7]))
    else $error("return timing or gie wrong");
  reset_vec_a: assert property ($fell(sys_rst_i) |->
    pc_load_o && program_counter_o == 0 && !status_flag_register_o[7])
    else $error("reset vector wrong");
endmodule
bind cis_sequencer cis_sequencer_monitor #(.NSRC(NSRC), .PCW(PCW)) u_mon (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .irq_src_en_i(irq_src_en_i),
  .instr_done_i(instr_done_i),
  .clear_global_enable_instr_i(clear_global_enable_instr_i),
  .return_from_handler_instr_i(return_from_handler_instr_i),
  .busy_o(busy_o), .pc_load_o(pc_load_o), .program_counter_o(program_counter_o),
  .stack_wr_o(stack_wr_o), .stack_addr_o(stack_addr_o),
  .status_flag_register_o(status_flag_register_o), .ack_o(ack_o));

// file: tb/core_interrupt_sequencer_tb_top.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
module core_interrupt_sequencer_tb_top;
  reg mclk_i, sys_rst_i, done, sei, clear_global_enable_instr, return_from_handler_instr, fwr, swr;
  reg [7:0] evt, en, fdat, sdat;
  reg [11:0] npc;
  reg [14:0] rows [0:2] = '{15'h11a5, 15'h32b4, 15'h7fff};
  wire busy_o, pc_load_o, stack_wr_o, stack_rd_o;
  wire [11:0] pc;
  wire [15:0] sa, sp_o;
  wire [7:0] swd, st, flags_o, ack_o, rdat;
  integer miscompares = 0, check_count = 0, cyc = 0, i, k;
  cis_sequencer uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .irq_evt_i(evt),
    .irq_level_type_i(8'h00), .irq_src_en_i(en), .flag_wr_i(fwr), .flag_wdata_i(fdat),
    .instr_done_i(done), .sleeping_i(1'b0), .wake_ready_i(1'b1),
    .set_global_enable_instr_i(sei), .clear_global_enable_instr_i(clear_global_enable_instr),
    .return_from_handler_instr_i(return_from_handler_instr), .next_pc_i(npc), .status_wr_i(swr),
    .status_wdata_i(sdat), .sp_wr_i(1'b0), .sp_wdata_i(16'h0000), .stack_rdata_i(rdat),
    .busy_o(busy_o), .pc_load_o(pc_load_o), .program_counter_o(pc),
    .stack_wr_o(stack_wr_o), .stack_rd_o(stack_rd_o), .stack_addr_o(sa),
    .stack_wdata_o(swd), .status_flag_register_o(st), .sp_o(sp_o),
    .flags_o(flags_o), .ack_o(ack_o));
  cis_stack_model u_stk (.mclk_i(mclk_i), .rd_i(stack_rd_o), .wr_i(stack_wr_o),
    .addr_i(sa), .wdata_i(swd), .rdata_o(rdat));
  ////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////
  task tick;
    @(negedge mclk_i);
  endtask
  task chk(input [63:0] n, input [15:0] e, input [15:0] s);
  begin
    check_count = check_count + 1;
    if (e !== s)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %0s exp %h got %h", n, e, s);
    end
  end
  endtask
  // bounded wait for ack (0) or pc load (1)
  task wt(input sel);
  begin
    k = 0;
    while ((sel ? pc_load_o : |ack_o) !== 1'b1 && k < 12)
    begin
      tick;
      k = k + 1;
    end
  end
  endtask
  task take(input [2:0] s);
  begin
    wt(1'b0);
    done = 1'b0;
    chk("ack", 16'h0001 << s, {8'h00, ack_o});
    chk("entry st", 16'h0015, {8'h00, st});
    wt(1'b1);
    chk("vector", {13'h0000, s} + 16'h0001, {4'h0, pc});
    chk("flag", 16'h0000, {15'h0000, flags_o[s]});
  end
  endtask
  task back;
  begin
    // the return can only be decoded once the vector jump has finished
    k = 0;
    while (busy_o !== 1'b0 && k < 12)
    begin
      tick;
      k = k + 1;
    end
    return_from_handler_instr = 1'b1;
    done = 1'b1;
    tick;
    return_from_handler_instr = 1'b0;
    done = 1'b0;
    wt(1'b1);
    chk("ret pc", {4'h0, npc}, {4'h0, pc});
    chk("ret st", 16'h0095, {8'h00, st});
    chk("ret sp", 16'h025f, sp_o);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {sys_rst_i, done, sei, clear_global_enable_instr, return_from_handler_instr, fwr, swr} = 7'h40;
    {evt, fdat, sdat, npc} = 36'h0;
    en = 8'hff;
    repeat (2) tick;
    sys_rst_i = 1'b0;
    tick;
    chk("sp", 16'h025f, sp_o);
    chk("st", 16'h0000, {8'h00, st});
    swr = 1'b1;
    sdat = 8'h95;
    tick;
    swr = 1'b0;
    // table rows: source and return address
    for (i = 0; i < 3; i = i + 1)
    begin
      npc = rows[i][11:0];
      evt[rows[i][14:12]] = 1'b1;
      tick;
      evt = 8'h00;
      done = 1'b1;
      take(rows[i][14:12]);
      back;
    end
    // flags latched with gie set, clear-enable in the cycle they first request
    evt = 8'h05;
    tick;
    evt = 8'h00;
    clear_global_enable_instr = 1'b1;
    done = 1'b1;
    tick;
    {clear_global_enable_instr, done} = 2'b00;
    repeat (3) tick;
    chk("cli ack", 16'h0000, {8'h00, ack_o});
    chk("held", 16'h0005, {8'h00, flags_o});
    sei = 1'b1;
    done = 1'b1;
    tick;
    sei = 1'b0;
    chk("sei ack", 16'h0000, {8'h00, ack_o});
    take(3'd0);
    back;
    repeat (3) tick;
    chk("post ret", 16'h0000, {8'h00, ack_o});
    done = 1'b1;
    take(3'd2);
    back;
    // disabled source keeps its flag, then cleared by write-one
    en = 8'hfd;
    evt = 8'h02;
    tick;
    evt = 8'h00;
    done = 1'b1;
    repeat (3) tick;
    done = 1'b0;
    chk("dis ack", 16'h0000, {8'h00, ack_o});
    chk("dis flag", 16'h0002, {8'h00, flags_o});
    {fwr, fdat} = 9'h102;
    tick;
    fwr = 1'b0;
    tick;
    chk("w1c", 16'h0000, {8'h00, flags_o});
    conclude;
  end
endmodule
